// ---- src/vhp_pkg.sv ----
// Purpose: shared constants for the video host and plane bus block
// Assumes: 10 MHz core clock, four 8-bit plane buses
// Notes:   register offsets, field positions, reset values and timing
package vhp_pkg;

  // clock and phase timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GATE_NS       = 200;  // least time the address gate stays low
  localparam int ROW_NS        = 200;  // least row strobe low time
  localparam int COL_NS        = 200;  // least column strobe low time
  localparam int GATE_CYC      = (GATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_CYC       = (ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_CYC       = (COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;

  // widths
  localparam int PLANES   = 4;
  localparam int PLANE_W  = 8;
  localparam int BUS_W    = PLANES * PLANE_W;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int HADDR_W  = 15;

  // register offsets
  localparam logic [7:0] REG_STATUS0    = 8'h02;
  localparam logic [7:0] REG_MODE       = 8'h03;
  localparam logic [7:0] REG_WRITE_MASK = 8'h04;
  localparam logic [7:0] REG_READ_PLANE = 8'h05;
  localparam logic [7:0] REG_FEATURE    = 8'h0a;
  localparam logic [7:0] REG_VCTRL      = 8'h11;

  // field positions
  localparam int FEAT_B0         = 0;
  localparam int FEAT_B1         = 1;
  localparam int VCTRL_CLR_B     = 4;  // written as zero clears the pending flag
  localparam int VCTRL_FLOAT_B   = 5;  // request line released when set
  localparam int STAT_IRQ_B      = 7;
  localparam int STAT_PEN_B      = 0;
  localparam int MODE_GRAPHICS_MODE_FLAG_B    = 0;

  // plane bus positions used in the address gate phase
  localparam int GATE_A10_POS    = 3 * PLANE_W + 4;  // plane 3 bits 4..7
  localparam int GATE_A6_POS     = 3 * PLANE_W;      // plane 3 bits 0..3
  localparam int GATE_A14_POS    = 2 * PLANE_W;      // plane 2 bit 0
  localparam int GATE_PEN_POS    = 2 * PLANE_W + 1;  // plane 2 bit 1

  // reset values
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RST_VCTRL   = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [3:0] RST_WMASK   = 4'hf;
  localparam logic [1:0] RST_RPLANE  = 2'h0;

  // memory cycle states
  typedef enum logic [2:0] {
    VHP_IDLE = 3'b000,
    VHP_GATE = 3'b001,
    VHP_ROW  = 3'b010,
    VHP_COL  = 3'b011,
    VHP_DONE = 3'b100
  } vhp_state_t;

endpackage : vhp_pkg

// ---- src/vhp_sync.sv ----
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   output follows once the second and third stages agree
`timescale 1ns/1ps
module vhp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // core clock
  input  wire logic         i_rstn,  // async reset, active low
  input  wire logic [W-1:0] i_d,     // raw pin levels
  output logic      [W-1:0] o_q      // filtered levels
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q;
  logic [W-1:0] next_q;

  // accept a level only when stages two and three agree
  always_comb begin
    next_q = q;
    for (int b = 0; b < W; b++) begin
      if (s2[b] == s3[b]) begin
        next_q[b] = s3[b];
      end
    end
  end

  // stage flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

  assign o_q = q;
endmodule : vhp_sync

// ---- src/vhp_top.sv ----
// Purpose: host port and video plane bus control of a graphics controller
// Assumes: host selects, read level and event line are pins; registers via plain port
// Notes:   one memory cycle per select; ready held low until the cycle is done
// Functional notes
// - address gate phase puts CPU address 10..14 on plane 3 high and plane 2 bit 0
// - address gate phase puts light pen level on plane 2 bit 1
// - otherwise each plane bus is eight bidirectional data/address lines
// - feature outputs drive inverted feature register bits 0 and 1
// - interrupt request output is high while an interrupt is pending
// - interrupt output floats when control register 11h bit 5 is set
// - pending interrupt reads back as status 0 bit 7
// - ready low until the memory access completes; host stretches its cycle
// - ready floats whenever video memory is not selected
// - one shared active-low output enable for reading all planes
// - address gate strobe low routes system address and light pen to plane pins
// - active-low column strobe to the planes in memory cycles
// - active-low row strobe to the planes in memory cycles
// - buffer select high while memory or port space is selected
// - graphics mode output high in graphics, low in alphanumeric mode
// - four active-low plane write strobes, only masked-in planes written
// - host pulls memory select low to request a memory access
// - host pulls port select low for any port access
// - row, column strobe and output enable shared; write strobe per plane
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module vhp_top (
  input  wire logic        I_CLK,                 // 10 MHz core clock
  input  wire logic        I_RSTN,                // async reset, active low
  // register port
  input  wire logic [7:0]  I_REG_ADDR,            // register offset
  input  wire logic [7:0]  I_REG_WDATA,           // write data
  input  wire logic        I_REG_WR,              // write strobe
  input  wire logic        I_REG_RD,              // read strobe
  output logic      [7:0]  O_REG_RDATA,           // read data, cycle after strobe
  // host side pins
  input  wire logic        I_VIDEO_MEM_SELECT_N,  // memory access request, low
  input  wire logic        I_PORT_SELECT_N,       // port access, low
  input  wire logic        I_HOST_READ,           // read direction, high
  input  wire logic [7:0]  I_HOST_WDATA,          // host write byte
  input  wire logic [5:0]  I_HOST_ADDR_LO,        // host address bits 0..5
  input  wire logic        I_IRQ_EVENT,           // interrupt source level
  output logic      [7:0]  O_HOST_RDATA,          // byte read from the planes
  output logic             O_IRQ,                 // interrupt request level
  output logic             O_IRQ_OE,              // request line driven
  output logic             O_READY,               // access done
  output logic             O_READY_OE,            // ready line driven
  output logic             O_BUFFER_SELECT,       // external data buffer enable
  // feature and mode outputs
  output logic             O_FEATURE_OUT_0_N,     // feature bit 0, inverted
  output logic             O_FEATURE_OUT_1_N,     // feature bit 1, inverted
  output logic             O_GRAPHICS_MODE_FLAG,  // graphics mode active
  // plane side pins
  input  wire logic [31:0] I_PLANE_BUS,           // plane 3..0 bus levels in
  output logic      [31:0] O_PLANE_BUS,           // plane bus drive values
  output logic      [31:0] O_PLANE_BUS_OE,        // plane bus drive enables
  output logic             O_SYS_ADDR_GATE_N,     // address gate strobe, low
  output logic             O_ROW_STROBE_N,        // row strobe, low
  output logic             O_COLUMN_STROBE_N,     // column strobe, low
  output logic             O_PLANE_OUTPUT_ENABLE_N, // shared read enable, low
  output logic      [3:0]  O_PLANE_WRITE_N        // per-plane write strobes, low
);

  localparam int PW = vhp_pkg::PLANE_W;

  // synchronised pin levels
  logic [3:0] raw_pins;
  logic [3:0] sync_pins;
  logic       mem_sel;
  logic       port_sel;
  logic       host_read;
  logic       irq_level;
  logic       irq_level_d;

  assign raw_pins = {I_IRQ_EVENT, I_HOST_READ, ~I_PORT_SELECT_N, ~I_VIDEO_MEM_SELECT_N};

  vhp_sync #(
    .W (4)
  ) u_sync (
    .i_clk  (I_CLK),
    .i_rstn (I_RSTN),
    .i_d    (raw_pins),
    .o_q    (sync_pins)
  );

  assign mem_sel   = sync_pins[0];
  assign port_sel  = sync_pins[1];
  assign host_read = sync_pins[2];
  assign irq_level = sync_pins[3];

  // software registers
  logic [7:0] feature;
  logic [7:0] vctrl;
  logic [7:0] mode;
  logic [3:0] wmask;
  logic [1:0] rplane;
  logic       irq_pend;
  logic       pen_latch;
  logic [7:0] rdata;
  logic [7:0] next_feature;
  logic [7:0] next_vctrl;
  logic [7:0] next_mode;
  logic [3:0] next_wmask;
  logic [1:0] next_rplane;
  logic       next_irq_pend;
  logic       next_pen_latch;
  logic [7:0] next_rdata;
  logic       irq_rise;
  logic       pen_cap;
  logic       pen_val;

  assign irq_rise = irq_level & ~irq_level_d;

  // register writes, reads and the pending flag
  always_comb begin
    next_feature   = feature;
    next_vctrl     = vctrl;
    next_mode      = mode;
    next_wmask     = wmask;
    next_rplane    = rplane;
    next_irq_pend  = irq_pend;
    next_pen_latch = pen_cap ? pen_val : pen_latch;
    next_rdata     = 8'h00;
    if (I_REG_WR) begin
      case (I_REG_ADDR)
        vhp_pkg::REG_FEATURE:    next_feature = I_REG_WDATA;
        vhp_pkg::REG_MODE:       next_mode    = I_REG_WDATA;
        vhp_pkg::REG_WRITE_MASK: next_wmask   = I_REG_WDATA[3:0];
        vhp_pkg::REG_READ_PLANE: next_rplane  = I_REG_WDATA[1:0];
        vhp_pkg::REG_VCTRL: begin
          next_vctrl = I_REG_WDATA;
          if (!I_REG_WDATA[vhp_pkg::VCTRL_CLR_B]) begin
            next_irq_pend = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    if (irq_rise) begin
      next_irq_pend = 1'b1;
    end
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        vhp_pkg::REG_STATUS0: begin
          next_rdata[vhp_pkg::STAT_IRQ_B] = irq_pend;
          next_rdata[vhp_pkg::STAT_PEN_B] = pen_latch;
        end
        vhp_pkg::REG_MODE:       next_rdata = mode;
        vhp_pkg::REG_WRITE_MASK: next_rdata = {4'h0, wmask};
        vhp_pkg::REG_READ_PLANE: next_rdata = {6'h00, rplane};
        vhp_pkg::REG_FEATURE:    next_rdata = feature;
        vhp_pkg::REG_VCTRL:      next_rdata = vctrl;
        default:                 next_rdata = 8'h00;
      endcase
    end
  end

  // register state
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      feature     <= vhp_pkg::RST_FEATURE;
      vctrl       <= vhp_pkg::RST_VCTRL;
      mode        <= vhp_pkg::RST_MODE;
      wmask       <= vhp_pkg::RST_WMASK;
      rplane      <= vhp_pkg::RST_RPLANE;
      irq_pend    <= 1'b0;
      pen_latch   <= 1'b0;
      rdata       <= 8'h00;
      irq_level_d <= 1'b0;
    end else begin
      feature     <= next_feature;
      vctrl       <= next_vctrl;
      mode        <= next_mode;
      wmask       <= next_wmask;
      rplane      <= next_rplane;
      irq_pend    <= next_irq_pend;
      pen_latch   <= next_pen_latch;
      rdata       <= next_rdata;
      irq_level_d <= irq_level;
    end
  end

  // memory cycle sequencer
  vhp_pkg::vhp_state_t                state;
  vhp_pkg::vhp_state_t                next_state;
  logic [vhp_pkg::CNT_W-1:0]          cnt;
  logic [vhp_pkg::CNT_W-1:0]          next_cnt;
  logic [8:0]                         gate_addr;   // CPU address 6..14
  logic [8:0]                         next_gate_addr;
  logic [7:0]                         host_rdata;
  logic [7:0]                         next_host_rdata;
  logic                               cyc_read;
  logic                               next_cyc_read;
  logic [7:0]                         read_byte;

  localparam logic [vhp_pkg::CNT_W-1:0] GATE_LAST =
    vhp_pkg::CNT_W'(vhp_pkg::GATE_CYC - 1);
  localparam logic [vhp_pkg::CNT_W-1:0] ROW_LAST  =
    vhp_pkg::CNT_W'(vhp_pkg::ROW_CYC - 1);
  localparam logic [vhp_pkg::CNT_W-1:0] COL_LAST  =
    vhp_pkg::CNT_W'(vhp_pkg::COL_CYC - 1);

  // plane byte selected for a host read
  always_comb begin
    case (rplane)
      2'h0:    read_byte = I_PLANE_BUS[0*PW +: PW];
      2'h1:    read_byte = I_PLANE_BUS[1*PW +: PW];
      2'h2:    read_byte = I_PLANE_BUS[2*PW +: PW];
      default: read_byte = I_PLANE_BUS[3*PW +: PW];
    endcase
  end

  // light pen level sampled from its shared pin at the end of the gate phase
  assign pen_val = I_PLANE_BUS[vhp_pkg::GATE_PEN_POS];
  assign pen_cap = (state == vhp_pkg::VHP_GATE) && (cnt == GATE_LAST);

  // next state: gate, row, column, then done until the select drops
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_gate_addr  = gate_addr;
    next_host_rdata = host_rdata;
    next_cyc_read   = cyc_read;
    case (state)
      vhp_pkg::VHP_IDLE: begin
        if (mem_sel) begin
          next_state    = vhp_pkg::VHP_GATE;
          next_cnt      = '0;
          next_cyc_read = host_read;
        end
      end
      vhp_pkg::VHP_GATE: begin
        if (cnt == GATE_LAST) begin
          // external muxes present address 6..14 on released plane pins
          next_gate_addr[3:0] = I_PLANE_BUS[vhp_pkg::GATE_A6_POS +: 4];
          next_gate_addr[7:4] = I_PLANE_BUS[vhp_pkg::GATE_A10_POS +: 4];
          next_gate_addr[8]   = I_PLANE_BUS[vhp_pkg::GATE_A14_POS];
          next_state          = vhp_pkg::VHP_ROW;
          next_cnt            = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      vhp_pkg::VHP_ROW: begin
        if (cnt == ROW_LAST) begin
          next_state = vhp_pkg::VHP_COL;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      vhp_pkg::VHP_COL: begin
        if (cnt == COL_LAST) begin
          if (cyc_read) begin
            next_host_rdata = read_byte;
          end
          next_state = vhp_pkg::VHP_DONE;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      vhp_pkg::VHP_DONE: begin
        if (!mem_sel) begin
          next_state = vhp_pkg::VHP_IDLE;
        end
      end
      default: begin
        next_state = vhp_pkg::VHP_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state      <= vhp_pkg::VHP_IDLE;
      cnt        <= '0;
      gate_addr  <= 9'h000;
      host_rdata <= 8'h00;
      cyc_read   <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      gate_addr  <= next_gate_addr;
      host_rdata <= next_host_rdata;
      cyc_read   <= next_cyc_read;
    end
  end

  // plane bus drive: row address in row phase, write data in column phase
  logic in_gate;
  logic in_row;
  logic in_col;
  logic col_write;

  assign in_gate   = (state == vhp_pkg::VHP_GATE);
  assign in_row    = (state == vhp_pkg::VHP_ROW);
  assign in_col    = (state == vhp_pkg::VHP_COL);
  assign col_write = in_col && !cyc_read;

  genvar gp;
  generate
    for (gp = 0; gp < vhp_pkg::PLANES; gp++) begin : g_plane
      // each plane is its own bidirectional byte lane, released while gated
      assign O_PLANE_BUS[gp*PW +: PW]    = in_row ? {gate_addr[1:0], I_HOST_ADDR_LO}
                                                  : I_HOST_WDATA;
      assign O_PLANE_BUS_OE[gp*PW +: PW] = (!in_gate && (in_row ||
                                           (col_write && wmask[gp]))) ?
                                           8'hff : 8'h00;
      assign O_PLANE_WRITE_N[gp]         = ~(col_write && wmask[gp]);
    end
  endgenerate

  // shared strobes
  assign O_SYS_ADDR_GATE_N       = ~in_gate;
  assign O_ROW_STROBE_N          = ~(in_row || in_col);
  assign O_COLUMN_STROBE_N       = ~in_col;
  assign O_PLANE_OUTPUT_ENABLE_N = ~(in_col && cyc_read);

  // host side outputs
  assign O_READY         = (state == vhp_pkg::VHP_DONE);
  assign O_READY_OE      = mem_sel;
  assign O_BUFFER_SELECT = mem_sel || port_sel;
  assign O_IRQ           = irq_pend;
  assign O_IRQ_OE        = ~vctrl[vhp_pkg::VCTRL_FLOAT_B];
  assign O_HOST_RDATA    = host_rdata;
  assign O_REG_RDATA     = rdata;

  // feature and mode outputs
  assign O_FEATURE_OUT_0_N    = ~feature[vhp_pkg::FEAT_B0];
  assign O_FEATURE_OUT_1_N    = ~feature[vhp_pkg::FEAT_B1];
  assign O_GRAPHICS_MODE_FLAG = mode[vhp_pkg::MODE_GRAPHICS_MODE_FLAG_B];

endmodule : vhp_top

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for vhp_top
// Assumes: 100 ns clock, plane model on the far side
// Notes:   expected bytes are queued, a monitor pops and compares
`timescale 1ns/1ps
module tb_top;
  logic clk, rstn, reg_wr_stb, reg_rd_stb, mem_sel_n, port_sel_n, host_read, irq_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, host_wdata, host_rdata;
  logic [5:0] host_addr_lo;
  logic irq, irq_oe, ready, ready_oe, buf_sel, feat0_n, feat1_n, graphics_mode_flag, gate_n, row_n, col_n;
  logic oe_n, m_pen, rd_q, rdy_q;
  logic [3:0] we_n;
  logic [31:0] bus_in, bus_out, bus_oe;
  logic [14:6] m_addr;
  logic [14:0] a1, a2;
  logic [7:0] d1, d2, d3, exp_reg[$], exp_mem[$];
  int err_count, samples_checked, cyc;

  vhp_top i_vhp_top (
    .I_CLK(clk), .I_RSTN(rstn), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .I_REG_WR(reg_wr_stb), .I_REG_RD(reg_rd_stb), .O_REG_RDATA(reg_rdata),
    .I_VIDEO_MEM_SELECT_N(mem_sel_n), .I_PORT_SELECT_N(port_sel_n), .I_HOST_READ(host_read),
    .I_HOST_WDATA(host_wdata), .I_HOST_ADDR_LO(host_addr_lo), .I_IRQ_EVENT(irq_event),
    .O_HOST_RDATA(host_rdata), .O_IRQ(irq), .O_IRQ_OE(irq_oe), .O_READY(ready),
    .O_READY_OE(ready_oe), .O_BUFFER_SELECT(buf_sel), .O_FEATURE_OUT_0_N(feat0_n),
    .O_FEATURE_OUT_1_N(feat1_n), .O_GRAPHICS_MODE_FLAG(graphics_mode_flag), .I_PLANE_BUS(bus_in),
    .O_PLANE_BUS(bus_out), .O_PLANE_BUS_OE(bus_oe), .O_SYS_ADDR_GATE_N(gate_n),
    .O_ROW_STROBE_N(row_n), .O_COLUMN_STROBE_N(col_n), .O_PLANE_OUTPUT_ENABLE_N(oe_n),
    .O_PLANE_WRITE_N(we_n));
  vhp_plane_model i_vhp_plane_model (
    .i_clk(clk), .i_addr(m_addr), .i_pen(m_pen), .i_dev(bus_out), .i_dev_oe(bus_oe),
    .i_gate_n(gate_n), .i_row_n(row_n), .i_col_n(col_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .o_bus(bus_in));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_stb <= 1'b1;
    reg_addr   <= a;
    reg_wdata  <= d;
    @(posedge clk);
    reg_wr_stb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    exp_reg.push_back(e);
    @(posedge clk);
    reg_rd_stb <= 1'b1;
    reg_addr   <= a;
    @(posedge clk);
    reg_rd_stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : reg_rd

  // one host memory cycle; on a read d is the expected byte
  task automatic mem_cycle(input logic rd, input logic [14:0] a, input logic [7:0] d,
                           input logic pen);
    int n = 0;
    if (rd) exp_mem.push_back(d);
    @(posedge clk);
    m_addr       <= a[14:6];
    m_pen        <= pen;
    host_addr_lo <= a[5:0];
    host_wdata   <= d;
    host_read    <= rd;
    mem_sel_n    <= 1'b0;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("ready", 8'h01, {7'h0, ready});
    @(posedge clk) mem_sel_n <= 1'b1;
    n = 0;
    while (ready_oe !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("ready_oe", 8'h00, {7'h0, ready_oe});
    repeat (3) @(posedge clk);
  endtask : mem_cycle

  // monitor: pops the oldest note when a result appears
  always @(posedge clk) begin
    rd_q  <= reg_rd_stb;
    rdy_q <= ready;
    if (rd_q) check("reg_rdata", exp_reg.pop_front(), reg_rdata);
    if (ready && !rdy_q && host_read) check("host_rdata", exp_mem.pop_front(), host_rdata);
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {rstn, reg_wr_stb, reg_rd_stb, host_read, irq_event, m_pen} = '0;
    {mem_sel_n, port_sel_n} = 2'b11;
    {reg_addr, reg_wdata, host_wdata, host_addr_lo, m_addr} = '0;
    void'($urandom(32'hc2aee4ee));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("irq_oe", 8'h01, {7'h0, irq_oe});
    check("feature", 8'h03, {6'h0, feat1_n, feat0_n});
    $display("test reset done");
    for (int v = 0; v < 4; v++) begin
      reg_wr(vhp_pkg::REG_FEATURE, 8'(v));
      reg_wr(vhp_pkg::REG_MODE, 8'(v));
      @(negedge clk);
      check("feature", 8'(~v & 3), {6'h0, feat1_n, feat0_n});
      check("graphics", 8'(v & 1), {7'h0, graphics_mode_flag});
    end
    reg_rd(vhp_pkg::REG_FEATURE, 8'h03);
    reg_rd(vhp_pkg::REG_MODE, 8'h03);
    reg_rd(8'h7f, 8'h00);
    $display("test pins done");
    a1 = 15'($urandom);
    a2 = a1 ^ 15'h00c0;
    d1 = 8'($urandom);
    d2 = ~d1;
    d3 = d1 ^ 8'h3c;
    reg_wr(vhp_pkg::REG_WRITE_MASK, 8'h0f);
    mem_cycle(1'b0, a1, d1, 1'b0);
    mem_cycle(1'b0, a2, d2, 1'b1);
    reg_wr(vhp_pkg::REG_WRITE_MASK, 8'h05);
    mem_cycle(1'b0, a1, d3, 1'b0);
    for (int p = 0; p < 4; p++) begin
      reg_wr(vhp_pkg::REG_READ_PLANE, 8'(p));
      mem_cycle(1'b1, a1, p[0] ? d1 : d3, 1'b0);
    end
    mem_cycle(1'b1, a2, d2, 1'b1);
    reg_rd(vhp_pkg::REG_WRITE_MASK, 8'h05);
    $display("test memory done");
    @(posedge clk) irq_event <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("irq", 8'h01, {7'h0, irq});
    reg_rd(vhp_pkg::REG_STATUS0, 8'h81);
    reg_wr(vhp_pkg::REG_VCTRL, 8'h30);
    @(negedge clk);
    check("irq_oe", 8'h00, {7'h0, irq_oe});
    check("irq", 8'h01, {7'h0, irq});
    reg_wr(vhp_pkg::REG_VCTRL, 8'h00);
    @(negedge clk);
    check("irq", 8'h00, {7'h0, irq});
    reg_rd(vhp_pkg::REG_STATUS0, 8'h01);
    $display("test interrupt done");
    @(posedge clk) port_sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("buffer_select", 8'h01, {7'h0, buf_sel});
    check("ready_oe", 8'h00, {7'h0, ready_oe});
    check("gate", 8'h01, {7'h0, gate_n});
    @(posedge clk) port_sel_n <= 1'b1;
    $display("test port select done");
    tally_and_finish();
  end
endmodule : tb_top

// ---- verif/vhp_plane_model.sv ----
// Purpose: far-side model: address muxes and four DRAM planes
// Assumes: strobes sampled on the core clock
// Notes:   released lines show the inverse of their last level
`timescale 1ns/1ps
module vhp_plane_model (
  input  wire logic        i_clk,    // clock
  input  wire logic [14:6] i_addr,   // host address 6..14
  input  wire logic        i_pen,    // light pen switch
  input  wire logic [31:0] i_dev,    // device drive values
  input  wire logic [31:0] i_dev_oe, // device drive enables
  input  wire logic        i_gate_n, // address gate
  input  wire logic        i_row_n,  // row strobe
  input  wire logic        i_col_n,  // column strobe
  input  wire logic        i_oe_n,   // shared read enable
  input  wire logic [3:0]  i_we_n,   // plane write strobes
  output logic      [31:0] o_bus     // resolved bus level
);
  logic [7:0]  mem [4][256];
  logic [7:0]  row;
  logic [31:0] last;
  logic [31:0] drv;
  // far-side drive: muxes in the gate phase, planes on a read
  always_comb begin
    drv = ~last;
    if (!i_gate_n) begin
      drv[31:24] = i_addr[13:6];
      drv[17:16] = {i_pen, i_addr[14]};
    end
    if (!i_oe_n) begin
      for (int p = 0; p < 4; p++) drv[8*p+:8] = mem[p][row];
    end
    o_bus = (i_dev_oe & i_dev) | (~i_dev_oe & drv);
  end
  // row latch on the shared strobe, per-plane write capture
  always @(posedge i_clk) begin
    last <= o_bus;
    if (!i_row_n && i_col_n) row <= o_bus[7:0];
    for (int p = 0; p < 4; p++) if (!i_we_n[p]) mem[p][row] <= o_bus[8*p+:8];
  end
endmodule : vhp_plane_model

// ---- verif/vhp_top_props.sv ----
// Purpose: port-level checks for vhp_top
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every vhp_top instance
`timescale 1ns/1ps
module vhp_top_props (
  input wire logic        I_CLK,                   // clock
  input wire logic        I_RSTN,                  // reset, low
  input wire logic [7:0]  I_REG_ADDR,              // reg offset
  input wire logic [7:0]  I_REG_WDATA,             // reg data
  input wire logic        I_REG_WR,                // write strobe
  input wire logic        I_REG_RD,                // read strobe
  input wire logic [7:0]  O_REG_RDATA,             // read data
  input wire logic        O_IRQ,                   // request level
  input wire logic        O_IRQ_OE,                // request driven
  input wire logic        O_READY,                 // ready
  input wire logic        O_READY_OE,              // ready driven
  input wire logic        O_BUFFER_SELECT,         // buffer enable
  input wire logic        O_FEATURE_OUT_0_N,       // feature 0
  input wire logic        O_FEATURE_OUT_1_N,       // feature 1
  input wire logic        O_GRAPHICS_MODE_FLAG,    // graphics
  input wire logic [31:0] O_PLANE_BUS_OE,          // plane enables
  input wire logic        O_SYS_ADDR_GATE_N,       // address gate
  input wire logic        O_ROW_STROBE_N,          // row strobe
  input wire logic        O_COLUMN_STROBE_N,       // column strobe
  input wire logic        O_PLANE_OUTPUT_ENABLE_N, // read enable
  input wire logic [3:0]  O_PLANE_WRITE_N          // write strobes
);
  logic [7:0] wd_q;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // write data of the previous cycle
  always_ff @(posedge I_CLK) wd_q <= I_REG_WDATA;
  property p_gate_free;
    !O_SYS_ADDR_GATE_N |-> O_PLANE_BUS_OE == 32'h0 && O_ROW_STROBE_N && O_COLUMN_STROBE_N;
  endproperty
  a_gate_free: assert property (p_gate_free) else $error("plane bus driven in gate");
  property p_cycle;
    $fell(O_SYS_ADDR_GATE_N) |-> ##1 !O_SYS_ADDR_GATE_N
      ##1 (O_SYS_ADDR_GATE_N && !O_ROW_STROBE_N && O_COLUMN_STROBE_N)
      ##2 (!O_ROW_STROBE_N && !O_COLUMN_STROBE_N) ##2 O_READY;
  endproperty
  a_cycle: assert property (p_cycle) else $error("memory cycle order wrong");
  property p_read_oe;
    !O_PLANE_OUTPUT_ENABLE_N |-> !O_COLUMN_STROBE_N && O_PLANE_WRITE_N == 4'hf
      && O_PLANE_BUS_OE == 32'h0;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("read enable misplaced");
  property p_write;
    O_PLANE_WRITE_N != 4'hf |-> !O_COLUMN_STROBE_N && O_PLANE_OUTPUT_ENABLE_N;
  endproperty
  a_write: assert property (p_write) else $error("write strobe misplaced");
  property p_rdy;
    $rose(O_READY) |-> O_READY_OE && O_BUFFER_SELECT;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready while undriven");
  property p_buf;
    O_READY_OE |-> O_BUFFER_SELECT;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer select low");
  property p_feat;
    I_REG_WR && I_REG_ADDR == vhp_pkg::REG_FEATURE
      |=> {O_FEATURE_OUT_1_N, O_FEATURE_OUT_0_N} == ~wd_q[1:0];
  endproperty
  a_feat: assert property (p_feat) else $error("feature pins wrong");
  property p_irq_oe;
    I_REG_WR && I_REG_ADDR == vhp_pkg::REG_VCTRL |=> O_IRQ_OE == !wd_q[5];
  endproperty
  a_irq_oe: assert property (p_irq_oe) else $error("request float wrong");
  property p_mode;
    I_REG_WR && I_REG_ADDR == vhp_pkg::REG_MODE |=> O_GRAPHICS_MODE_FLAG == wd_q[0];
  endproperty
  a_mode: assert property (p_mode) else $error("graphics flag wrong");
  property p_stat;
    I_REG_RD && I_REG_ADDR == vhp_pkg::REG_STATUS0 |=> O_REG_RDATA[7] == $past(O_IRQ);
  endproperty
  a_stat: assert property (p_stat) else $error("status pending bit wrong");
endmodule : vhp_top_props

bind vhp_top vhp_top_props i_props (
  .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .O_IRQ(O_IRQ),
  .O_IRQ_OE(O_IRQ_OE), .O_READY(O_READY), .O_READY_OE(O_READY_OE),
  .O_BUFFER_SELECT(O_BUFFER_SELECT), .O_FEATURE_OUT_0_N(O_FEATURE_OUT_0_N),
  .O_FEATURE_OUT_1_N(O_FEATURE_OUT_1_N), .O_GRAPHICS_MODE_FLAG(O_GRAPHICS_MODE_FLAG),
  .O_PLANE_BUS_OE(O_PLANE_BUS_OE), .O_SYS_ADDR_GATE_N(O_SYS_ADDR_GATE_N),
  .O_ROW_STROBE_N(O_ROW_STROBE_N), .O_COLUMN_STROBE_N(O_COLUMN_STROBE_N),
  .O_PLANE_OUTPUT_ENABLE_N(O_PLANE_OUTPUT_ENABLE_N), .O_PLANE_WRITE_N(O_PLANE_WRITE_N)
);
